/* File: logic/scpm_pkg.sv */
// package for subsystem clock pin mode select
// assumes a single core_clk domain; selection bits come from cpu-side logic
// Operation
// R1 - start bit set, or start clear with ext select clear and pin enable set, puts the pins in resonator mode.
// R2 - start clear with ext select and pin enable both set gives external clock input on the second pin.
// R3 - after reset both pins are input ports until software picks a mode.
// R4 - with no subsystem clock in use both pins act as plain input ports.
// R5 - software keeps the three selection bits steady while the subsystem clock runs.
// R6 - software waits out oscillator stabilisation with a timer before using the clock.
// R7 - software starts no pin-clocked peripheral when only the subsystem clock runs or in stop mode.
// R8 - any other bit combination leaves both pins in input port mode.
package scpm_pkg;
    typedef enum logic [1:0] {
        SCPM_PORT,
        SCPM_RESONATOR,
        SCPM_EXT_CLOCK
    } scpm_mode_type;
    localparam logic SCPM_START_RESET  = 1'b0;
    localparam logic SCPM_EXTSEL_RESET = 1'b0;
    localparam logic SCPM_PINEN_RESET  = 1'b0;
    // pin levels are async; fewer stages risk metastable port data
    localparam int   SCPM_SYNC_STAGES  = 2;
endpackage : scpm_pkg

/* File: logic/scpm_top.sv */
// pin mode selection for the two subsystem clock pins
// assumes selection bits are written by same-clock logic; pins are async
`timescale 1ns/1ps
module scpm_top (
    input  wire logic                   core_clk,
    input  wire logic                   srst,
    input  wire logic                   sub_osc_start_select,
    input  wire logic                   ext_sub_clock_select,
    input  wire logic                   sub_clock_pin_enable,
    input  wire logic                   sub_osc_input_pin,
    input  wire logic                   sub_osc_output_pin,
    output scpm_pkg::scpm_mode_type     pin_mode,
    output logic                        osc_enable,
    output logic                        ext_clock_enable,
    output logic                        sub_pin_port_a,
    output logic                        sub_pin_port_b,
    output logic                        sub_clock_in_use
);
    scpm_pkg::scpm_mode_type next_pin_mode;
    logic                    start_q;
    logic                    extsel_q;
    logic                    pinen_q;
    logic                    pin_a_synced;
    logic                    pin_b_synced;

    // bits held in flops so reset yields port mode regardless of inputs
    always_ff @(posedge core_clk) begin
        if (srst) begin
            start_q  <= scpm_pkg::SCPM_START_RESET; // R3
            extsel_q <= scpm_pkg::SCPM_EXTSEL_RESET;
            pinen_q  <= scpm_pkg::SCPM_PINEN_RESET;
        end else begin
            start_q  <= sub_osc_start_select;
            extsel_q <= ext_sub_clock_select;
            pinen_q  <= sub_clock_pin_enable;
        end
    end

    always_comb begin
        if (start_q) begin
            next_pin_mode = scpm_pkg::SCPM_RESONATOR; // R1
        end else if (pinen_q && !extsel_q) begin
            next_pin_mode = scpm_pkg::SCPM_RESONATOR; // R1
        end else if (pinen_q && extsel_q) begin
            next_pin_mode = scpm_pkg::SCPM_EXT_CLOCK; // R2
        end else begin
            next_pin_mode = scpm_pkg::SCPM_PORT; // R8
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pin_mode <= scpm_pkg::SCPM_PORT; // R3
        end else begin
            pin_mode <= next_pin_mode;
        end
    end

    // pins are async: only the last sync stage feeds the port data
    scpm_sync #(
        .STAGES   (scpm_pkg::SCPM_SYNC_STAGES)
    ) sync_pin_a (
        .core_clk (core_clk),
        .srst     (srst),
        .async_in (sub_osc_input_pin),
        .sync_out (pin_a_synced)
    );

    scpm_sync #(
        .STAGES   (scpm_pkg::SCPM_SYNC_STAGES)
    ) sync_pin_b (
        .core_clk (core_clk),
        .srst     (srst),
        .async_in (sub_osc_output_pin),
        .sync_out (pin_b_synced)
    );

    // first pin port read gives zero only in resonator mode, when it carries the clock
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sub_pin_port_a <= 1'b0; // R3
        end else begin
            case (pin_mode)
                scpm_pkg::SCPM_PORT: begin
                    sub_pin_port_a <= pin_a_synced; // R4
                end
                scpm_pkg::SCPM_EXT_CLOCK: begin
                    sub_pin_port_a <= pin_a_synced; // R2
                end
                default: begin
                    sub_pin_port_a <= 1'b0; // R1
                end
            endcase
        end
    end

    // second pin only reads as a port in plain port mode
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sub_pin_port_b <= 1'b0; // R3
        end else begin
            case (pin_mode)
                scpm_pkg::SCPM_PORT: begin
                    sub_pin_port_b <= pin_b_synced; // R4
                end
                default: begin
                    sub_pin_port_b <= 1'b0; // R2
                end
            endcase
        end
    end

    assign osc_enable       = (pin_mode == scpm_pkg::SCPM_RESONATOR); // R1
    assign ext_clock_enable = (pin_mode == scpm_pkg::SCPM_EXT_CLOCK); // R2
    assign sub_clock_in_use = osc_enable | ext_clock_enable;

    // select bits reach the mode two edges later: bit flop, then mode flop
    mode_start_a: assert property (@(posedge core_clk) // R1
        disable iff (srst)
        sub_osc_start_select |-> ##2 osc_enable)
        else $error("start bit did not give resonator mode");

    mode_resonator_a: assert property (@(posedge core_clk) // R1
        disable iff (srst)
        (!sub_osc_start_select && !ext_sub_clock_select
         && sub_clock_pin_enable) |-> ##2 osc_enable)
        else $error("pin enable alone did not give resonator mode");

    mode_ext_a: assert property (@(posedge core_clk) // R2
        disable iff (srst)
        (!sub_osc_start_select && ext_sub_clock_select
         && sub_clock_pin_enable) |-> ##2 (ext_clock_enable && !osc_enable))
        else $error("external clock mode not entered");

    // second pin carries the clock, so its port read must stay low
    ext_port_a: assert property (@(posedge core_clk) // R2
        disable iff (srst)
        ext_clock_enable |=> (sub_pin_port_b == 1'b0))
        else $error("second pin read as port in external mode");

    // latency of three edges assumes two sync stages
    ext_pass_a: assert property (@(posedge core_clk) // R2
        disable iff (srst)
        ext_clock_enable [*3] |=>
        (sub_pin_port_a == $past(sub_osc_input_pin, 3)))
        else $error("first pin not read as port in external mode");

    res_port_a: assert property (@(posedge core_clk) // R1
        disable iff (srst)
        osc_enable |=> (!sub_pin_port_a && !sub_pin_port_b))
        else $error("resonator pins read as port data");

    reset_port_a: assert property (@(posedge core_clk) // R3
        srst |=> (pin_mode == scpm_pkg::SCPM_PORT && !sub_clock_in_use))
        else $error("pins not in port mode after reset");

    reset_data_a: assert property (@(posedge core_clk) // R3
        srst |=> (!sub_pin_port_a && !sub_pin_port_b))
        else $error("port data not cleared by reset");

    port_pass_a: assert property (@(posedge core_clk) // R4
        disable iff (srst)
        (pin_mode == scpm_pkg::SCPM_PORT) |=>
        (sub_pin_port_a == $past(pin_a_synced)))
        else $error("port data not passed in port mode");

    port_delay_a: assert property (@(posedge core_clk) // R4
        disable iff (srst)
        (pin_mode == scpm_pkg::SCPM_PORT) [*3] |=>
        (sub_pin_port_a == $past(sub_osc_input_pin, 3)))
        else $error("first pin level late or lost in port mode");

    port_b_delay_a: assert property (@(posedge core_clk) // R4
        disable iff (srst)
        (pin_mode == scpm_pkg::SCPM_PORT) [*3] |=>
        (sub_pin_port_b == $past(sub_osc_output_pin, 3)))
        else $error("second pin level late or lost in port mode");

    other_port_a: assert property (@(posedge core_clk) // R8
        disable iff (srst)
        (!sub_osc_start_select && !sub_clock_pin_enable) |-> ##2
        (pin_mode == scpm_pkg::SCPM_PORT))
        else $error("unlisted combination left port mode");

    idle_clock_a: assert property (@(posedge core_clk) // R8
        disable iff (srst)
        (!sub_osc_start_select && !sub_clock_pin_enable) |-> ##2
        !sub_clock_in_use)
        else $error("clock enabled by unlisted combination");

    // main scenarios: each mode, a return to port mode, a reset release
    cov_res_c: cover property (@(posedge core_clk) osc_enable);
    cov_ext_c: cover property (@(posedge core_clk) ext_clock_enable);
    cov_back_c: cover property (@(posedge core_clk)
        sub_clock_in_use ##1 !sub_clock_in_use);
    cov_port_c: cover property (@(posedge core_clk)
        pin_mode == scpm_pkg::SCPM_PORT && sub_pin_port_a);
    cov_reset_c: cover property (@(posedge core_clk) srst ##1 !srst);
endmodule : scpm_top

// synchroniser for one asynchronous pin level; depth is a parameter
module scpm_sync #(
    parameter int STAGES = scpm_pkg::SCPM_SYNC_STAGES
) (
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic [STAGES-1:0] chain;

    // one stage would let a metastable level reach the port logic
    if (STAGES < 2) begin : g_depth_check
        $error("scpm_sync needs at least two stages");
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            chain <= {STAGES{1'b0}};
        end else begin
            chain <= {chain[STAGES-2:0], async_in};
        end
    end

    // nothing outside the chain reads an early stage
    assign sync_out = chain[STAGES-1];
endmodule : scpm_sync

/* File: verification/scpm_src.sv */
// resonator or external clock source on the two subsystem pins
// assumes the bench says which source runs; otherwise pins show port levels
`timescale 1ns/1ps
module scpm_src (
    input  wire logic core_clk,
    input  wire logic xtal,
    input  wire logic clk_in,
    input  wire logic lvl_a,
    input  wire logic lvl_b,
    output logic      pin_a,
    output logic      pin_b
);
    logic ph = 1'b0;
    // free toggle only matters while a source runs
    always @(posedge core_clk) ph <= ~ph;
    assign pin_a = xtal ? ~ph : lvl_a;
    assign pin_b = (xtal | clk_in) ? ph : lvl_b;
endmodule : scpm_src

/* File: verification/tb.sv */
// bench for the subsystem clock pin mode select
// assumes scpm_top and the source model; checks mode, enables and port data
`timescale 1ns/1ps
module tb;
    logic core_clk = 1'b0, srst = 1'b1, st = 1'b0, ex = 1'b0, en = 1'b0;
    logic xt = 1'b0, ck = 1'b0, la = 1'b0, lb = 1'b0, pa, pb;
    logic osc, ext, port_a, port_b, in_use;
    scpm_pkg::scpm_mode_type pin_mode, m;
    int err_total = 0, checks_done = 0;
    scpm_src src (.core_clk(core_clk), .xtal(xt), .clk_in(ck), .lvl_a(la),
        .lvl_b(lb), .pin_a(pa), .pin_b(pb));
    scpm_top dut (.core_clk(core_clk), .srst(srst),
        .sub_osc_start_select(st), .ext_sub_clock_select(ex),
        .sub_clock_pin_enable(en), .sub_osc_input_pin(pa),
        .sub_osc_output_pin(pb), .pin_mode(pin_mode), .osc_enable(osc),
        .ext_clock_enable(ext), .sub_pin_port_a(port_a),
        .sub_pin_port_b(port_b), .sub_clock_in_use(in_use));
    initial forever #5 core_clk = ~core_clk;
    task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %b expected %b", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task automatic test_reset;
        chk({pin_mode, osc}, {scpm_pkg::SCPM_PORT, 1'b0});
        chk({ext, in_use, port_a}, 3'h0);
        chk({2'h0, port_b}, 3'h0);
        $display("reset test done");
    endtask : test_reset
    task automatic test_port;
        for (int i = 0; i < 4; i++) begin
            {la, lb} = i[1:0];
            step(4);
            chk({in_use, port_a, port_b}, {1'b0, la, lb});
        end
        $display("port test done");
    endtask : test_port
    task automatic test_modes;
        for (int i = 0; i < 8; i++) begin
            {st, ex, en} = i[2:0];
            m = st ? scpm_pkg::SCPM_RESONATOR : !en ? scpm_pkg::SCPM_PORT :
                ex ? scpm_pkg::SCPM_EXT_CLOCK : scpm_pkg::SCPM_RESONATOR;
            xt = (m == scpm_pkg::SCPM_RESONATOR);
            ck = (m == scpm_pkg::SCPM_EXT_CLOCK);
            {la, lb} = 2'h3;
            step(4);
            chk({1'b0, pin_mode}, {1'b0, m});
            chk({osc, ext, in_use}, {xt, ck, xt | ck});
            chk({1'b0, port_a, port_b}, {1'b0, ~xt, ~(xt | ck)});
        end
        $display("mode test done");
    endtask : test_modes
    task automatic test_mid_reset;
        {st, ex, en} = 3'h1;
        step(4);
        srst = 1'b1;
        {st, ex, en} = 3'h0;
        {xt, ck} = 2'h0;
        step(2);
        chk({pin_mode, osc}, {scpm_pkg::SCPM_PORT, 1'b0});
        chk({ext, port_a, port_b}, 3'h0);
        srst = 1'b0;
        step(2);
        chk({pin_mode, in_use}, {scpm_pkg::SCPM_PORT, 1'b0});
        $display("mid-run reset test done");
    endtask : test_mid_reset
    initial begin
        step(4);
        srst = 1'b0;
        step(1);
        test_reset();
        test_port();
        test_modes();
        test_mid_reset();
        end_of_test();
    end
    initial begin
        #5000;
        err_total++;
        end_of_test();
    end
endmodule : tb
